// file: src/serial_status_flags.sv
// Purpose: receive/transmit status flags of a serial unit
// Assumes: character-level receiver and transmitter outside
// Notes:   standby acts like a synchronous reset of the flags
// Function
// - async parity mismatch against odd/even select sets parity fault
// - parity fault clears on reset, standby, or read-1 then write-0
// - clearing receive-on leaves parity fault unchanged
// - parity error loads holding register but not receive-full
// - reception halts while parity fault reads 1
// - synchronous mode: receive error flag inhibits transmission
// - parity checked only in async mode, resets to 0
// - transmit-done is read-only, writes ignored
// - read-1 write-0 of buffer-empty clears transmit-done
// - DMA write to transmit holding register clears transmit-done
// - transmit-done set on reset, standby, transmit-on cleared
// - last bit sent with buffer empty sets transmit-done
// - async multiprocessor format captures received multiproc bit
// - received multiproc bit is read-only, resets to 0
// - clearing receive-on keeps received multiproc bit
// - receive-full still set at next character: overrun, discard
// =============================================================
// module
`timescale 1ns/100ps
module serial_status_flags #(
	parameter int DATA_W = serial_status_pkg::DATA_W,
	parameter int DEPTH  = serial_status_pkg::FIFO_DEPTH
) (
	input  wire logic                                 ref_clk,
	input  wire logic                                 rst_n,
	input  wire logic                                 standbyReq,
	input  wire logic [serial_status_pkg::ADDR_W-1:0] addr,
	input  wire logic [7:0]                           wrData,
	input  wire logic                                 wrStrobe,
	input  wire logic                                 rdStrobe,
	output      logic [7:0]                           rdData,
	input  wire logic                                 rxCharValid,
	output      logic                                 rxCharReady,
	input  wire logic [DATA_W-1:0]                    rxCharData,
	input  wire logic                                 rxCharParity,
	input  wire logic                                 rxCharMpBit,
	input  wire logic                                 dmaWrite,
	input  wire logic [DATA_W-1:0]                    dmaData,
	input  wire logic                                 txTake,
	input  wire logic                                 lastBitSent,
	output      logic [DATA_W-1:0]                    txData,
	output      logic                                 rxFull,
	output      logic                                 txEmpty,
	output      logic                                 rxEnable,
	output      logic                                 txEnable
);
	localparam int WORD_W = DATA_W + 2;

	// refuse widths the 8-bit register port cannot carry
	if (DATA_W < 1 || DATA_W > 8) begin : g_chk
		$error("serial_status_flags data width out of range");
	end

	// =========================================================
	// declarations
	logic [7:0]              ctrl_reg;
	logic [7:0]              rdData_reg;
	logic [DATA_W-1:0]       rxHold_reg;
	logic [DATA_W-1:0]       txHold_reg;
	logic [3:0]              flag_reg;
	logic [3:0]              armed_reg;
	logic                    txDone_reg;
	logic                    mpBit_reg;
	logic [3:0]              setV;
	logic [3:0]              clrSw;
	logic [3:0]              clrHw;
	logic [3:0]              swBits;
	logic [DATA_W-1:0]       popData;
	logic                    popParity;
	logic                    popMp;
	logic                    mismatch;
	logic                    popEv;
	logic                    asyncMode;
	logic                    parErr;
	logic                    overrunEv;
	logic                    loadEv;
	logic                    rxBlocked;
	logic                    wrStatus;
	logic                    rdStatus;
	logic                    tendSet;
	logic                    tendClr;
	logic [7:0]              statusWord;
	logic [7:0]              rdNext;

	rx_char_if #(.WORD_W(WORD_W)) rxBus ();

	// =========================================================
	// receive buffer and parity
	char_fifo #(
		.WORD_W (WORD_W),
		.DEPTH  (DEPTH)
	) u_fifo (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.inValid (rxCharValid),
		.inReady (rxCharReady),
		.inWord  ({rxCharMpBit, rxCharParity, rxCharData}),
		.drain   (rxBus.src)
	);

	assign popData   = rxBus.word[DATA_W-1:0];
	assign popParity = rxBus.word[DATA_W];
	assign popMp     = rxBus.word[DATA_W+1];

	rx_parity_check #(
		.W (DATA_W)
	) u_par (
		.data      (popData),
		.parityBit (popParity),
		.oddSel    (ctrl_reg[serial_status_pkg::CT_ODD]),
		.mismatch  (mismatch)
	);

	// =========================================================
	// receive character handling
	assign asyncMode = ~ctrl_reg[serial_status_pkg::CT_SYNC];
	assign rxBlocked = flag_reg[serial_status_pkg::FL_PER]
		| flag_reg[serial_status_pkg::FL_ORER];
	assign rxEnable  = ctrl_reg[serial_status_pkg::CT_RE] & ~rxBlocked & ~standbyReq;
	assign rxBus.ready = rxEnable;
	assign popEv     = rxBus.valid & rxBus.ready;
	assign overrunEv = popEv & flag_reg[serial_status_pkg::FL_RX_FULL_FLAG];
	assign parErr    = popEv & ~overrunEv & asyncMode
		& ctrl_reg[serial_status_pkg::CT_PAREN] & mismatch;
	assign loadEv    = popEv & ~overrunEv;

	// =========================================================
	// bus decode
	assign wrStatus = wrStrobe & (addr == serial_status_pkg::OFS_STATUS);
	assign rdStatus = rdStrobe & (addr == serial_status_pkg::OFS_STATUS);

	// hardware set terms of the clearable flags
	assign setV[serial_status_pkg::FL_PER]  = parErr;
	assign setV[serial_status_pkg::FL_ORER] = overrunEv;
	assign setV[serial_status_pkg::FL_RX_FULL_FLAG] = loadEv & ~parErr;
	assign setV[serial_status_pkg::FL_TX_BUFFER_EMPTY_FLAG] = txTake;

	// hardware clear terms besides software
	assign clrHw[serial_status_pkg::FL_PER]  = 1'b0;
	assign clrHw[serial_status_pkg::FL_ORER] = 1'b0;
	assign clrHw[serial_status_pkg::FL_RX_FULL_FLAG] = 1'b0;
	assign clrHw[serial_status_pkg::FL_TX_BUFFER_EMPTY_FLAG] = dmaWrite;

	// written value of each flag bit
	assign swBits[serial_status_pkg::FL_PER]  = wrData[serial_status_pkg::ST_PER];
	assign swBits[serial_status_pkg::FL_ORER] = wrData[serial_status_pkg::ST_ORER];
	assign swBits[serial_status_pkg::FL_RX_FULL_FLAG] = wrData[serial_status_pkg::ST_RX_FULL_FLAG];
	assign swBits[serial_status_pkg::FL_TX_BUFFER_EMPTY_FLAG] = wrData[serial_status_pkg::ST_TX_BUFFER_EMPTY_FLAG];

	// =========================================================
	// clearable flags, one slice per flag
	for (genvar i = 0; i < serial_status_pkg::NFLAG; i++) begin : g_flag
		assign clrSw[i] = wrStatus & armed_reg[i] & ~swBits[i];

		// arm on a read that sees the flag set
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				armed_reg[i] <= 1'b0;
			end else if (standbyReq || wrStatus || !flag_reg[i]) begin
				armed_reg[i] <= rdStatus & flag_reg[i];
			end else if (rdStatus) begin
				armed_reg[i] <= 1'b1;
			end
		end

		// flag state, set wins over clear
		// no receive-on term
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				flag_reg[i] <= serial_status_pkg::FLAG_RST[i];
			end else if (standbyReq) begin
				flag_reg[i] <= serial_status_pkg::FLAG_RST[i];
			end else if (setV[i]) begin
				flag_reg[i] <= 1'b1;
			end else if (clrSw[i] || clrHw[i]) begin
				flag_reg[i] <= 1'b0;
			end
		end
	end

	// =========================================================
	// control register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= serial_status_pkg::CTRL_RST;
		end else if (standbyReq) begin
			ctrl_reg <= serial_status_pkg::CTRL_RST;
		end else if (wrStrobe && addr == serial_status_pkg::OFS_CTRL) begin
			ctrl_reg <= wrData;
		end
	end

	// receive holding register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxHold_reg <= DATA_W'(serial_status_pkg::DATA_RST);
		end else if (loadEv) begin
			rxHold_reg <= popData;
		end
	end

	// transmit holding register, cpu or dma
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			txHold_reg <= DATA_W'(serial_status_pkg::DATA_RST);
		end else if (dmaWrite) begin
			txHold_reg <= dmaData;
		end else if (wrStrobe && addr == serial_status_pkg::OFS_TXDATA) begin
			txHold_reg <= wrData[DATA_W-1:0];
		end
	end

	// received multiprocessor bit
	// no receive-on term, holds
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mpBit_reg <= serial_status_pkg::MPB_RST;
		end else if (standbyReq) begin
			mpBit_reg <= serial_status_pkg::MPB_RST;
		end else if (loadEv && asyncMode && ctrl_reg[serial_status_pkg::CT_MULTI]) begin
			mpBit_reg <= popMp;
		end
	end

	// =========================================================
	// transmit-done flag
	// software clear of buffer-empty
	assign tendClr = (clrSw[serial_status_pkg::FL_TX_BUFFER_EMPTY_FLAG] & ~txTake) | dmaWrite;
	assign tendSet = ~ctrl_reg[serial_status_pkg::CT_TE]
		| (lastBitSent & flag_reg[serial_status_pkg::FL_TX_BUFFER_EMPTY_FLAG]);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			txDone_reg <= serial_status_pkg::TX_DONE_FLAG_RST;
		end else if (standbyReq || tendSet) begin
			txDone_reg <= 1'b1;
		end else if (tendClr) begin
			txDone_reg <= 1'b0;
		end
	end

	// =========================================================
	// status word and read port
	always_comb begin
		statusWord = 8'h00;
		statusWord[serial_status_pkg::ST_TX_BUFFER_EMPTY_FLAG] = flag_reg[serial_status_pkg::FL_TX_BUFFER_EMPTY_FLAG];
		statusWord[serial_status_pkg::ST_RX_FULL_FLAG] = flag_reg[serial_status_pkg::FL_RX_FULL_FLAG];
		statusWord[serial_status_pkg::ST_ORER] = flag_reg[serial_status_pkg::FL_ORER];
		statusWord[serial_status_pkg::ST_PER]  = flag_reg[serial_status_pkg::FL_PER];
		statusWord[serial_status_pkg::ST_TX_DONE_FLAG] = txDone_reg;
		statusWord[serial_status_pkg::ST_MPB]  = mpBit_reg;
	end

	// read data multiplexer, unmapped reads zero
	always_comb begin
		rdNext = 8'h00;
		case (addr)
			serial_status_pkg::OFS_STATUS: begin
				rdNext = statusWord;
			end
			serial_status_pkg::OFS_CTRL: begin
				rdNext = ctrl_reg;
			end
			serial_status_pkg::OFS_RXDATA: begin
				rdNext[DATA_W-1:0] = rxHold_reg;
			end
			serial_status_pkg::OFS_TXDATA: begin
				rdNext[DATA_W-1:0] = txHold_reg;
			end
			default: begin
				rdNext = 8'h00;
			end
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_reg <= 8'h00;
		end else if (rdStrobe) begin
			rdData_reg <= rdNext;
		end else begin
			rdData_reg <= 8'h00;
		end
	end

	// =========================================================
	// outputs
	assign rdData  = rdData_reg;
	assign txData  = txHold_reg;
	assign rxFull  = flag_reg[serial_status_pkg::FL_RX_FULL_FLAG];
	assign txEmpty = flag_reg[serial_status_pkg::FL_TX_BUFFER_EMPTY_FLAG];
	assign txEnable = ctrl_reg[serial_status_pkg::CT_TE] & ~standbyReq
		& ~(ctrl_reg[serial_status_pkg::CT_SYNC] & rxBlocked);

	// =========================================================
	// assertions
	sequence s_parLoad;
		parErr && !standbyReq;
	endsequence

	sequence s_parSeen;
		flag_reg[serial_status_pkg::FL_PER] && !rxFull;
	endsequence

	property p_parity_set;
		@(posedge ref_clk) disable iff (!rst_n)
		s_parLoad |=> s_parSeen;
	endproperty
	a_parity_set: assert property (p_parity_set) else $error("parity fault not set");

	property p_parity_clear;
		@(posedge ref_clk) disable iff (!rst_n)
		rdStatus && flag_reg[serial_status_pkg::FL_PER]
		##1 (wrStatus && !wrData[serial_status_pkg::ST_PER] && !parErr)
		|=> !flag_reg[serial_status_pkg::FL_PER];
	endproperty
	a_parity_clear: assert property (p_parity_clear) else $error("parity fault not cleared");

	property p_parity_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		!wrStatus && !standbyReq && !parErr |=> $stable(flag_reg[serial_status_pkg::FL_PER]);
	endproperty
	a_parity_hold: assert property (p_parity_hold) else $error("parity fault moved");

	property p_load_on_err;
		@(posedge ref_clk) disable iff (!rst_n)
		parErr |=> rxHold_reg == $past(popData) && !rxFull;
	endproperty
	a_load_on_err: assert property (p_load_on_err) else $error("bad load on parity error");

	property p_rx_halt;
		@(posedge ref_clk) disable iff (!rst_n)
		flag_reg[serial_status_pkg::FL_PER] |-> !popEv && !rxEnable;
	endproperty
	a_rx_halt: assert property (p_rx_halt) else $error("reception during fault");

	property p_tx_inhibit;
		@(posedge ref_clk) disable iff (!rst_n)
		ctrl_reg[serial_status_pkg::CT_SYNC] && rxBlocked |-> !txEnable;
	endproperty
	a_tx_inhibit: assert property (p_tx_inhibit) else $error("sync tx not inhibited");

	property p_tx_done_flag_dma;
		@(posedge ref_clk) disable iff (!rst_n)
		dmaWrite && !tendSet && !standbyReq |=> !txDone_reg ##0 txData == $past(dmaData);
	endproperty
	a_tx_done_flag_dma: assert property (p_tx_done_flag_dma) else $error("dma write kept done");

	property p_tx_done_flag_off;
		@(posedge ref_clk) disable iff (!rst_n)
		!ctrl_reg[serial_status_pkg::CT_TE] |=> txDone_reg;
	endproperty
	a_tx_done_flag_off: assert property (p_tx_done_flag_off) else $error("done not set when off");

	property p_tx_done_flag_last;
		@(posedge ref_clk) disable iff (!rst_n)
		lastBitSent && txEmpty |=> txDone_reg;
	endproperty
	a_tx_done_flag_last: assert property (p_tx_done_flag_last) else $error("done not set at end");

	property p_mpb_capture;
		@(posedge ref_clk) disable iff (!rst_n)
		loadEv && asyncMode && ctrl_reg[serial_status_pkg::CT_MULTI] && !standbyReq
		|=> mpBit_reg == $past(popMp);
	endproperty
	a_mpb_capture: assert property (p_mpb_capture) else $error("multiproc bit lost");

	property p_overrun;
		@(posedge ref_clk) disable iff (!rst_n)
		overrunEv && !standbyReq
		|=> flag_reg[serial_status_pkg::FL_ORER] && $stable(rxHold_reg);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");
endmodule : serial_status_flags

// file: src/serial_status_pkg.sv
// Purpose: shared constants for the serial status flag block
// Assumes: 8-bit register port, four word offsets
// Notes:   flag vector order is fixed by the FL_ indices below
// =============================================================
// package
package serial_status_pkg;
	// register port geometry
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 8;
	// register offsets
	localparam logic [1:0] OFS_STATUS = 2'h0;
	localparam logic [1:0] OFS_CTRL   = 2'h1;
	localparam logic [1:0] OFS_RXDATA = 2'h2;
	localparam logic [1:0] OFS_TXDATA = 2'h3;
	// status register bit positions
	localparam int ST_TX_BUFFER_EMPTY_FLAG = 7;
	localparam int ST_RX_FULL_FLAG = 6;
	localparam int ST_ORER = 5;
	localparam int ST_PER  = 3;
	localparam int ST_TX_DONE_FLAG = 2;
	localparam int ST_MPB  = 1;
	// control register bit positions
	localparam int CT_TE    = 5;
	localparam int CT_RE    = 4;
	localparam int CT_SYNC  = 3;
	localparam int CT_PAREN = 2;
	localparam int CT_ODD   = 1;
	localparam int CT_MULTI = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// clearable flag vector: index and reset values
	localparam int NFLAG   = 4;
	localparam int FL_PER  = 0;
	localparam int FL_ORER = 1;
	localparam int FL_RX_FULL_FLAG = 2;
	localparam int FL_TX_BUFFER_EMPTY_FLAG = 3;
	localparam logic [3:0] FLAG_RST = 4'h8;
	localparam logic       TX_DONE_FLAG_RST = 1'h1;
	localparam logic       MPB_RST  = 1'h0;
	localparam logic [7:0] DATA_RST = 8'h00;
endpackage : serial_status_pkg

// file: src/rx_char_if.sv
// Purpose: carrier for received characters between buffer and flag logic
// Assumes: word = {multiproc bit, parity bit, data}
// Notes:   valid/ready handshake, transfer when both high
// =============================================================
// interface
`timescale 1ns/100ps
interface rx_char_if #(parameter int WORD_W = 10);
	logic [WORD_W-1:0] word;
	logic              valid;
	logic              ready;
	modport src (output word, output valid, input ready);
	modport snk (input word, input valid, output ready);
endinterface : rx_char_if

// file: src/char_fifo.sv
// Purpose: flip-flop FIFO for received characters
// Assumes: one push and one pop per cycle at most each
// Notes:   full and empty are exact, read side stalls freely
// =============================================================
// module
`timescale 1ns/100ps
module char_fifo #(
	parameter int WORD_W = 10,
	parameter int DEPTH  = 8
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              inValid,
	output      logic              inReady,
	input  wire logic [WORD_W-1:0] inWord,
	rx_char_if.src                 drain
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULLC = CW'(DEPTH);

	// refuse depths the pointers cannot serve
	if (DEPTH < 2) begin : g_chk
		$error("char_fifo depth below two");
	end

	logic [WORD_W-1:0] mem_reg [DEPTH];
	logic [PW-1:0]     wrPtr_reg;
	logic [PW-1:0]     rdPtr_reg;
	logic [CW-1:0]     count_reg;
	logic              push;
	logic              pop;

	// handshake terms
	assign inReady     = (count_reg != FULLC);
	assign drain.valid = (count_reg != '0);
	assign drain.word  = mem_reg[rdPtr_reg];
	assign push        = inValid & inReady;
	assign pop         = drain.valid & drain.ready;

	// storage write
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_reg[wrPtr_reg] <= inWord;
		end
	end

	// pointers and fill count
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wrPtr_reg <= (wrPtr_reg == LAST) ? '0 : wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_reg <= (rdPtr_reg == LAST) ? '0 : rdPtr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule : char_fifo

// file: src/rx_parity_check.sv
// Purpose: parity comparison of one received character
// Assumes: parity bit sampled and presented with the data
// Notes:   purely combinational, result used at load time
// =============================================================
// module
`timescale 1ns/100ps
module rx_parity_check #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] data,
	input  wire logic         parityBit,
	input  wire logic         oddSel,
	output      logic         mismatch
);
	// refuse empty characters
	if (W < 1) begin : g_chk
		$error("rx_parity_check width below one");
	end

	// ones count incl. parity bit must be odd when odd selected
	assign mismatch = (^{data, parityBit}) != oddSel;
endmodule : rx_parity_check

// file: sim/remote_station.sv
// Purpose: remote serial station model feeding received characters
// Assumes: word is {multiproc bit, parity bit, data}
// Notes:   an offer is held until ready is seen high at an edge
// =============================================================
// station model
`timescale 1ns/100ps
module remote_station (
	input  wire logic       ref_clk,
	input  wire logic       rxCharReady,
	output      logic       rxCharValid,
	output      logic [7:0] rxCharData,
	output      logic       rxCharParity,
	output      logic       rxCharMpBit
);
	logic [9:0] pendQ[$];
	// queue one character for sending
	task automatic offer(input logic [9:0] w);
		pendQ.push_back(w);
	endtask : offer
	// idle values at time zero
	initial begin
		rxCharValid = 1'b0;
		{rxCharMpBit, rxCharParity, rxCharData} = 10'h000;
	end
	// present head, idle lines toggle so stale data is never read as good
	always @(posedge ref_clk) begin
		if (rxCharValid && rxCharReady)
			void'(pendQ.pop_front());
		rxCharValid <= (pendQ.size() > 0);
		if (pendQ.size() > 0)
			{rxCharMpBit, rxCharParity, rxCharData} <= pendQ[0];
		else
			{rxCharMpBit, rxCharParity, rxCharData} <= ~{rxCharMpBit, rxCharParity, rxCharData};
	end
endmodule : remote_station

// file: sim/serial_status_flags_tb_top.sv
// Purpose: self-checking bench for the serial status flag block
// Assumes: register read data stands in the cycle after the strobe
// Notes:   flag model kept in ints, compared at rdchk and clr status reads
// =============================================================
// bench
`timescale 1ns/100ps
module serial_status_flags_tb_top;
	logic       ref_clk;
	logic       rst_n = 1'b0;
	logic       standbyReq = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wrData = 8'h00;
	logic       wrStrobe = 1'b0;
	logic       rdStrobe = 1'b0;
	logic [7:0] rdData;
	logic       rxCharValid, rxCharReady, rxCharParity, rxCharMpBit;
	logic [7:0] rxCharData;
	logic       dmaWrite = 1'b0;
	logic [7:0] dmaData = 8'h00;
	logic       txTake = 1'b0;
	logic       lastBitSent = 1'b0;
	logic [7:0] txData;
	logic       rxFull, txEmpty, rxEnable, txEnable;
	int         err_count = 0;
	int         check_count = 0;
	int         cycles = 0;
	int         tx_buffer_empty_flag = 1, rx_full_flag = 0, orer = 0, parity_fault_flag = 0, tx_done_flag = 1, rx_multiproc_bit = 0;
	logic [7:0] ctl = 8'h00, rxd = 8'h00, v, dd;
	logic [9:0] pend[$];
	// =============================================================
	// instances
	serial_status_flags u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .standbyReq(standbyReq),
		.addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
		.rdData(rdData), .rxCharValid(rxCharValid), .rxCharReady(rxCharReady),
		.rxCharData(rxCharData), .rxCharParity(rxCharParity), .rxCharMpBit(rxCharMpBit),
		.dmaWrite(dmaWrite), .dmaData(dmaData), .txTake(txTake), .lastBitSent(lastBitSent),
		.txData(txData), .rxFull(rxFull), .txEmpty(txEmpty), .rxEnable(rxEnable),
		.txEnable(txEnable));
	remote_station u_peer (.ref_clk(ref_clk), .rxCharReady(rxCharReady),
		.rxCharValid(rxCharValid), .rxCharData(rxCharData), .rxCharParity(rxCharParity),
		.rxCharMpBit(rxCharMpBit));
	// clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 6000) begin
			err_count++;
			end_of_test();
		end
	end
	// =============================================================
	// tasks
	task automatic end_of_test();
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	function automatic logic [7:0] st();
		return {tx_buffer_empty_flag[0], rx_full_flag[0], orer[0], 1'b0, parity_fault_flag[0], tx_done_flag[0], rx_multiproc_bit[0], 1'b0};
	endfunction : st
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge ref_clk);
		wrStrobe <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] r);
		@(posedge ref_clk);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge ref_clk);
		rdStrobe <= 1'b0;
		#1;
		r = rdData;
	endtask : rd
	task automatic rdchk(input logic [1:0] a, input logic [7:0] e);
		logic [7:0] r;
		rd(a, r);
		chk(r, e);
	endtask : rdchk
	task automatic wrctl(input logic [7:0] c);
		ctl = c;
		if (!c[5])
			tx_done_flag = 1;
		wr(2'h1, c);
	endtask : wrctl
	// one-cycle pulse of {standby, dma, take, last bit}
	task automatic evt(input logic [3:0] k);
		@(posedge ref_clk);
		{standbyReq, dmaWrite, txTake, lastBitSent} <= k;
		@(posedge ref_clk);
		{standbyReq, dmaWrite, txTake, lastBitSent} <= 4'h0;
		#1;
	endtask : evt
	// wait for the station, then apply pending characters to the model
	task automatic settle();
		logic [9:0] w;
		for (int i = 0; i < 40 && u_peer.pendQ.size() > 0; i++)
			@(posedge ref_clk);
		repeat (4) @(posedge ref_clk);
		while (pend.size() > 0 && ctl[4] && parity_fault_flag == 0 && orer == 0) begin
			w = pend.pop_front();
			if (rx_full_flag != 0)
				orer = 1;
			else begin
				rxd = w[7:0];
				if (!ctl[3] && ctl[2] && w[8])
					parity_fault_flag = 1;
				else
					rx_full_flag = 1;
				if (!ctl[3] && ctl[0])
					rx_multiproc_bit = w[9];
			end
		end
	endtask : settle
	task automatic send(input logic bad);
		logic [7:0] d;
		logic       mp;
		d = 8'($urandom);
		mp = 1'($urandom);
		u_peer.offer({mp, ^d ^ ctl[1] ^ bad, d});
		pend.push_back({mp, bad, d});
		settle();
	endtask : send
	// read then write 0 to the masked status flags
	task automatic clr(input logic [7:0] m);
		@(posedge ref_clk);
		addr <= 2'h0;
		rdStrobe <= 1'b1;
		// write follows the read with no gap
		@(posedge ref_clk);
		rdStrobe <= 1'b0;
		wrData <= ~m;
		wrStrobe <= 1'b1;
		#1;
		chk(rdData, st());
		@(posedge ref_clk);
		wrStrobe <= 1'b0;
		#1;
		if (m[7] && tx_buffer_empty_flag != 0) begin
			tx_buffer_empty_flag = 0;
			tx_done_flag = ctl[5] ? 0 : 1;
		end
		if (m[6])
			rx_full_flag = 0;
		if (m[5])
			orer = 0;
		if (m[3])
			parity_fault_flag = 0;
		settle();
	endtask : clr
	// =============================================================
	// main sequence
	initial begin
		void'($urandom(75895));
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		wr(2'h0, 8'h00);
		rdchk(2'h0, st());
		wrctl(8'h20);
		chk({7'h0, txEnable}, 8'h01);
		clr(8'h80);
		rdchk(2'h0, st());
		evt(4'h2);
		tx_buffer_empty_flag = 1;
		evt(4'h1);
		tx_done_flag = 1;
		rdchk(2'h0, st());
		dd = 8'($urandom);
		@(posedge ref_clk);
		dmaData <= dd;
		evt(4'h4);
		tx_buffer_empty_flag = 0;
		tx_done_flag = 0;
		evt(4'h1);
		rdchk(2'h0, st());
		chk(txData, dd);
		chk({7'h0, txEmpty}, {7'h0, tx_buffer_empty_flag[0]});
		rdchk(2'h3, dd);
		wrctl(8'h00);
		rdchk(2'h0, st());
		// every parity select with good and bad characters
		for (int k = 0; k < 4; k++) begin
			wrctl(8'h15 | {6'h0, k[1], 1'b0});
			send(k[0]);
			rdchk(2'h0, st());
			chk({7'h0, rxFull}, {7'h0, rx_full_flag[0]});
			rdchk(2'h2, rxd);
			if (k[0]) begin
				wrctl(ctl & 8'hef);
				rdchk(2'h0, st());
			end
			clr(k[0] ? 8'h08 : 8'h40);
			rdchk(2'h0, st());
		end
		// reception blocked by a parity fault, then overrun
		wrctl(8'h14);
		send(1'b1);
		send(1'b0);
		chk({7'h0, rxEnable}, 8'h00);
		rdchk(2'h2, rxd);
		clr(8'h08);
		rdchk(2'h2, rxd);
		send(1'b0);
		rdchk(2'h0, st());
		rdchk(2'h2, rxd);
		// synchronous mode
		wrctl(8'h28);
		chk({7'h0, txEnable}, 8'h00);
		clr(8'h60);
		chk({7'h0, txEnable}, 8'h01);
		wrctl(8'h1c);
		send(1'b1);
		rdchk(2'h0, st());
		// fill the buffer until it refuses, then drain it
		clr(8'h40);
		wrctl(8'h00);
		repeat (9) send(1'b0);
		chk({7'h0, rxCharReady}, 8'h00);
		chk(8'(u_peer.pendQ.size()), 8'h01);
		pend.delete();
		wrctl(8'h10);
		for (int i = 0; i < 12; i++) begin
			rd(2'h0, v);
			wr(2'h0, ~v | 8'h80);
		end
		chk({7'h0, rxCharReady}, 8'h01);
		chk(8'(u_peer.pendQ.size()), 8'h00);
		// standby returns flags and control to reset values
		evt(4'h8);
		tx_buffer_empty_flag = 1;
		rx_full_flag = 0;
		orer = 0;
		parity_fault_flag = 0;
		tx_done_flag = 1;
		rx_multiproc_bit = 0;
		ctl = 8'h00;
		rdchk(2'h0, st());
		rdchk(2'h1, 8'h00);
		end_of_test();
	end
endmodule : serial_status_flags_tb_top
